// >>> logic/ps_cfg_pkg.sv
package ps_cfg_pkg;
    // power-on reset: 100 ms nominal, 10 ns clock
    localparam int POR_MS = 100;
    localparam int POR_CYCLES = POR_MS * 100_000;
    // internal init oscillator 10 MHz, from the 100 MHz clock
    localparam int CLK_MHZ = 100;
    localparam int OSC_MHZ = 10;
    localparam int OSC_DIV = CLK_MHZ / OSC_MHZ;
    // start-up clock cycles needed after load-complete rises
    localparam int INIT_CYCLES = 299;
    // auto-restart reset time-out, at most 40 us, rounded down
    localparam int RESTART_US = 40;
    localparam int RESTART_CYCLES = RESTART_US * CLK_MHZ;
    // bit of the first frame that enables the init-complete pin
    localparam int FRAME_BITS = 32;
    localparam int INIT_EN_BIT = 0;
    // reset values
    localparam logic [31:0] CNT_RST = 32'h0;

    typedef enum logic [2:0] {
        ST_POR, ST_RESET, ST_CONFIG, ST_INIT, ST_USER, ST_ERROR
    } cfg_state_t;

    // open-drain pins as seen by the device
    typedef struct packed {
        logic status_oe;
        logic done_oe;
        logic init_oe;
    } od_drive_t;
endpackage

// >>> logic/ps_cfg_slave.sv
// How it works
// [RULE_01] during power-on reset hold status and load-complete low, I/O high-Z
// [RULE_02] after 100 ms power-on reset release status; configure once it is high
// [RULE_03] weak pull-ups on before and during configuration, off in user mode; the code also keeps them off during power-on reset
// [RULE_04] memory holds status low during its own power-on reset
// [RULE_05] memory power-on delay is 100 ms or 2 ms by its delay select
// [RULE_06] rising config-request starts reset, configuration, initialization in order
// [RULE_07] stay in reset while config-request or status is low
// [RULE_08] config-request high leaves reset and releases status
// [RULE_09] memory drives load clock and shifts bits after status rises
// [RULE_10] sample each data bit on the rising edge of the load clock
// [RULE_11] release load-complete after all data without error; init starts
// [RULE_12] memory stops when load-complete high, resumes when it goes low
// [RULE_13] default init clocked by internal 10 MHz oscillator, self supplied
// [RULE_14] with start-up clock option, 299 cycles needed before user mode
// [RULE_15] user mode waits for start-up clocks; they do not affect configuration
// [RULE_16] init-complete driven low after first frame if enabled, released at end
// [RULE_17] unchained devices sync by start-up clock, never forcing load-complete
// [RULE_18] chained devices start init together on the shared load-complete rise
// [RULE_19] start-up clock keeps toggling while status low, at most 40 us
// [RULE_20] memory drives load clock low and data high at the end
// [RULE_21] external party pulls config-request low at least 2 us to reconfigure
// [RULE_22] falling config-request pulls status and load-complete low, I/O high-Z
// [RULE_23] reconfiguration begins once config-request high and status released
// [RULE_24] on error drive status low; auto-restart releases within 40 us
module ps_cfg_slave #(
    // power-on length in clk cycles; the default is the full 100 ms,
    // a bench may shorten it because ten million cycles is too long to run
    parameter int POR_LEN = ps_cfg_pkg::POR_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration pins, asynchronous
    input wire logic cfg_req_n,
    input wire logic status_in,
    input wire logic done_in,
    input wire logic load_clk,
    input wire logic serial_load_input,
    input wire logic usr_clk,
    // options and stream checks
    input wire logic usr_clk_en,
    input wire logic auto_restart,
    input wire logic [31:0] stream_bits,
    input wire logic crc_err,
    // open-drain drives, enable high means pulling low
    output ps_cfg_pkg::od_drive_t od_q,
    // user I/O control
    output logic io_hiz_q,
    output logic io_pullup_q,
    output logic user_mode_q,
    // received data
    output logic bit_valid_q,
    output logic bit_data_q
);
    import ps_cfg_pkg::*;

    logic [1:0] s_req, s_st, s_dn, s_lc, s_dat, s_uc;
    logic lc_d1_q, uc_d1_q, req_d1_q, dn_d1_q;
    logic lc_rise, uc_rise, dn_rise, req_fall;
    cfg_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d, bits_q, bits_d;
    logic [8:0] ic_q, ic_d;
    logic init_en_q, init_en_d;
    od_drive_t od_d;
    logic hiz_d, pu_d, um_d, bv_d, bd_d;

    // two-flop synchronisers; only the second stage is read
    always_ff @(posedge clk) begin
        s_req <= {s_req[0], cfg_req_n};
        s_st <= {s_st[0], status_in};
        s_dn <= {s_dn[0], done_in};
        s_lc <= {s_lc[0], load_clk};
        s_dat <= {s_dat[0], serial_load_input};
        s_uc <= {s_uc[0], usr_clk};
        lc_d1_q <= s_lc[1];
        uc_d1_q <= s_uc[1];
        req_d1_q <= s_req[1];
        dn_d1_q <= s_dn[1];
    end

    assign lc_rise = s_lc[1] & ~lc_d1_q;
    assign uc_rise = s_uc[1] & ~uc_d1_q;
    assign dn_rise = s_dn[1] & ~dn_d1_q;
    assign req_fall = ~s_req[1] & req_d1_q;

    // sequencer; counter reused for por, oscillator and time-out
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        bits_d = bits_q;
        ic_d = ic_q;
        init_en_d = init_en_q;
        bv_d = 1'b0;
        bd_d = bit_data_q;
        unique case (st_q)
            ST_POR: begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q == 32'(POR_LEN - 1)) begin // [RULE_02]
                    st_d = ST_RESET;
                end
            end
            ST_RESET: begin
                bits_d = CNT_RST;
                ic_d = '0;
                cnt_d = CNT_RST;
                init_en_d = 1'b0;
                // wait on both lines; status may be held by the memory
                if (s_req[1] && s_st[1]) begin // [RULE_07] [RULE_23]
                    st_d = ST_CONFIG; // [RULE_06]
                end
            end
            ST_CONFIG: begin
                // user clock edges are ignored here
                if (lc_rise) begin // [RULE_10] [RULE_15]
                    bv_d = 1'b1;
                    bd_d = s_dat[1];
                    bits_d = bits_q + 32'h1;
                    if (bits_q == 32'(INIT_EN_BIT)) begin
                        init_en_d = s_dat[1];
                    end
                end
                if (crc_err) begin
                    st_d = ST_ERROR; // [RULE_24]
                    cnt_d = CNT_RST;
                end else if (bits_q == stream_bits) begin
                    st_d = ST_INIT; // [RULE_11]
                    cnt_d = CNT_RST;
                end
            end
            ST_INIT: begin
                // wait for the shared line to rise before counting
                if (s_dn[1]) begin // [RULE_18]
                    if (usr_clk_en) begin
                        if (uc_rise) begin // [RULE_14]
                            ic_d = ic_q + 9'h1;
                        end
                    end else begin
                        cnt_d = cnt_q + 32'h1;
                        if (cnt_q == 32'(OSC_DIV - 1)) begin // [RULE_13]
                            cnt_d = CNT_RST;
                            ic_d = ic_q + 9'h1;
                        end
                    end
                end
                if (ic_q == 9'(INIT_CYCLES)) begin // [RULE_15]
                    st_d = ST_USER;
                end
            end
            ST_USER: begin
            end
            ST_ERROR: begin
                cnt_d = cnt_q + 32'h1;
                if (auto_restart &&
                    cnt_q == 32'(RESTART_CYCLES - 1)) begin // [RULE_24]
                    st_d = ST_RESET;
                end
            end
        endcase
        // falling request wins everywhere except power-on
        if (st_q != ST_POR && (req_fall || !s_req[1])) begin // [RULE_22]
            st_d = ST_RESET;
        end
    end

    // pin drives follow the next state so outputs stay registered
    always_comb begin
        od_d.status_oe = (st_d == ST_POR) || (st_d == ST_ERROR)
            || (st_d == ST_RESET && !s_req[1]); // [RULE_01] [RULE_08]
        od_d.done_oe = (st_d == ST_POR) || (st_d == ST_RESET)
            || (st_d == ST_CONFIG) || (st_d == ST_ERROR); // [RULE_11]
        od_d.init_oe = init_en_d
            && (st_d == ST_CONFIG || st_d == ST_INIT)
            && bits_d > 32'(FRAME_BITS - 1); // [RULE_16]
        hiz_d = (st_d != ST_USER); // [RULE_22]
        pu_d = (st_d != ST_USER) && (st_d != ST_POR); // [RULE_03]
        um_d = (st_d == ST_USER);
    end

    // state registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= ST_POR;
            cnt_q <= CNT_RST;
            bits_q <= CNT_RST;
            ic_q <= '0;
            init_en_q <= 1'b0;
            od_q <= '{status_oe: 1'b1, done_oe: 1'b1, init_oe: 1'b0};
            io_hiz_q <= 1'b1;
            io_pullup_q <= 1'b0;
            user_mode_q <= 1'b0;
            bit_valid_q <= 1'b0;
            bit_data_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bits_q <= bits_d;
            ic_q <= ic_d;
            init_en_q <= init_en_d;
            od_q <= od_d;
            io_hiz_q <= hiz_d;
            io_pullup_q <= pu_d;
            user_mode_q <= um_d;
            bit_valid_q <= bv_d;
            bit_data_q <= bd_d;
        end
    end

    // checks
    AST_POR_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_POR |-> od_q.status_oe && od_q.done_oe && io_hiz_q
            && !io_pullup_q) // [RULE_01]
        else $error("por drive wrong");
    AST_RESET_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_RESET && !s_st[1] |=> st_q != ST_CONFIG) // [RULE_07]
        else $error("left reset with status low");
    AST_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_RESET && s_req[1] |=> !od_q.status_oe) // [RULE_08]
        else $error("status not released");
    AST_SAMPLE: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_CONFIG && lc_rise && s_req[1] && !req_fall
            |=> bit_valid_q && bit_data_q == $past(s_dat[1])) // [RULE_10]
        else $error("bit not sampled");
    AST_DONE: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_INIT |-> !od_q.done_oe) // [RULE_11]
        else $error("load-complete held in init");
    AST_USER_PU: assert property (@(posedge clk) disable iff (sys_rst)
        user_mode_q |-> !io_pullup_q && !io_hiz_q) // [RULE_03]
        else $error("pull-ups in user mode");
    AST_INIT_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(user_mode_q) |-> $past(ic_q) == 9'(INIT_CYCLES)) // [RULE_14]
        else $error("user mode before init count");
    AST_REQ_FALL: assert property (@(posedge clk) disable iff (sys_rst)
        req_fall && st_q != ST_POR |=> od_q.status_oe && od_q.done_oe
            && io_hiz_q) // [RULE_22]
        else $error("request fall not honoured");
    AST_ERR: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_CONFIG && crc_err && s_req[1] |=> od_q.status_oe)
        // [RULE_24]
        else $error("error did not pull status");
    // status goes free on the very edge that ends power-on
    AST_POR_END: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_POR && cnt_q == 32'(POR_LEN - 1) && s_req[1]
            |=> !od_q.status_oe) // [RULE_02]
        else $error("status kept after power-on");
    // start-up clock edges in configuration must leave the init count alone
    AST_IC_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_CONFIG |-> ic_q == 9'h0) // [RULE_15]
        else $error("init count moved in configuration");
    // init-complete is never pulled once user mode is reached
    AST_INIT_PIN: assert property (@(posedge clk) disable iff (sys_rst)
        user_mode_q |-> !od_q.init_oe) // [RULE_16]
        else $error("init-complete held in user mode");
    // auto-restart frees status when the time-out runs out
    AST_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
        st_q == ST_ERROR && auto_restart && s_req[1]
            && cnt_q == 32'(RESTART_CYCLES - 1)
            |=> st_q == ST_RESET && !od_q.status_oe) // [RULE_24]
        else $error("restart did not free status");
    COV_USER: cover property (@(posedge clk) $rose(user_mode_q));
    COV_USRCLK: cover property (@(posedge clk)
        $rose(user_mode_q) && usr_clk_en);
    COV_RESTART: cover property (@(posedge clk)
        st_q == ST_ERROR ##1 st_q == ST_RESET);
    COV_ERR: cover property (@(posedge clk) st_q == ST_ERROR);
    COV_RECFG: cover property (@(posedge clk) user_mode_q && req_fall);
endmodule

// >>> sim/cfg_mem_model.sv
module cfg_mem_model #(
    // power-on delays in ns; a bench may scale them down to save run time
    parameter realtime SHORT_NS = 2.0e6,
    parameter realtime LONG_NS = 1.0e8
) (
    // memory pins
    input wire logic loader_por_delay_select,
    input wire logic oe_in,
    input wire logic cs_n,
    output logic oe_hold,
    output logic load_clk,
    output logic data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int i;
    // own power-on delay first, holding the shared status line low
    initial begin
        oe_hold = 1'b1;
        load_clk = 1'b0;
        data_out = 1'b1;
        #(loader_por_delay_select ? SHORT_NS : LONG_NS);
        oe_hold = 1'b0;
        forever begin
            wait (oe_in && !cs_n);
            #1000;
            // clock only runs inside a frame, so the device sees no stray edge
            for (i = 0; i < 32 && oe_in && !cs_n; i++) begin
                data_out = (i == 0) || (i % 3 == 1);
                #62.5 load_clk = 1'b1;
                #62.5 load_clk = 1'b0;
            end
            data_out = 1'b1;
            // a frame cut by status going low ends without load-complete
            wait (cs_n || !oe_in);
            if (cs_n) begin
                wait (!cs_n);
            end
        end
    end
endmodule

// >>> sim/passive_serial_config_slave_tb.sv
module passive_serial_config_slave_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ps_cfg_pkg::*;
    logic clk, sys_rst, cfg_req_n, usr_clk, usr_clk_en;
    logic load_clk, din, oe_hold, status_w, done_w;
    od_drive_t od_q;
    logic io_hiz_q, io_pullup_q, user_mode_q, bit_valid_q, bit_data_q;
    logic [5:0] obs;
    logic crc_err, auto_restart, exp_bit;
    // shortened power-on so the run stays small
    localparam int TB_POR = 2000;
    int fail_count, cmp_count, nbits;
    // both lines have pull-ups; either party may pull status low
    assign status_w = !(od_q.status_oe || oe_hold);
    assign done_w = !od_q.done_oe; // nobody else pulls it
    assign obs = {user_mode_q, io_pullup_q, io_hiz_q, od_q};

    ps_cfg_slave #(.POR_LEN(TB_POR)) i_ps_cfg_slave (.clk(clk),
        .sys_rst(sys_rst),
        .cfg_req_n(cfg_req_n), .status_in(status_w), .done_in(done_w),
        .load_clk(load_clk), .serial_load_input(din), .usr_clk(usr_clk),
        .usr_clk_en(usr_clk_en), .auto_restart(auto_restart),
        .stream_bits(32'h20), .crc_err(crc_err), .od_q(od_q),
        .io_hiz_q(io_hiz_q), .io_pullup_q(io_pullup_q),
        .user_mode_q(user_mode_q), .bit_valid_q(bit_valid_q),
        .bit_data_q(bit_data_q));
    // memory delay outlasts the device's so it holds status for a while
    cfg_mem_model #(.SHORT_NS(30000.0)) i_cfg_mem_model (
        .loader_por_delay_select(1'b1),
        .oe_in(status_w), .cs_n(done_w), .oe_hold(oe_hold),
        .load_clk(load_clk), .data_out(din));

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on one observed output; running out ends the run
    task automatic wait_obs(input int idx, input logic v, input int lim);
        for (int k = 0; k < lim && obs[idx] !== v; k++) tick(1);
        chk(obs[idx], v, "wait ran out");
        if (obs[idx] !== v) wrap_up();
    endtask
    // the start-up clock is only ever paused by the bench, never cut
    task automatic usr_pulses(input int n);
        repeat (n) begin
            usr_clk = 1'b1;
            tick(4);
            usr_clk = 1'b0;
            tick(4);
        end
    endtask
    // every sampled bit must match the memory's pattern
    always @(posedge clk) begin
        if (bit_valid_q === 1'b1) begin
            exp_bit = (nbits == 0) || (nbits % 3 == 1);
            chk(bit_data_q, exp_bit, "bit");
            nbits++;
        end
    end

    task automatic power_on();
        tick(TB_POR - 20);
        chk(od_q.status_oe, 1'b1, "status early");
        chk(io_hiz_q, 1'b1, "io not hiz");
        wait_obs(2, 1'b0, 100);
        chk(io_pullup_q, 1'b1, "no pullup");
        chk(status_w, 1'b0, "memory hold lost");
    endtask
    task automatic err_restart();
        cfg_req_n = 1'b0;
        usr_clk_en = 1'b0;
        wait_obs(2, 1'b1, 80);
        tick(200);
        crc_err = 1'b1;
        auto_restart = 1'b1;
        cfg_req_n = 1'b1;
        wait_obs(2, 1'b0, 100);
        wait_obs(2, 1'b1, 100);
        crc_err = 1'b0;
        tick(3900);
        chk(od_q.status_oe, 1'b1, "restart early");
        wait_obs(2, 1'b0, 200);
        configure();
        init_internal();
    endtask
    task automatic configure();
        nbits = 0;
        wait_obs(1, 1'b0, 2000);
        tick(2);
        chk(nbits == 32, 1'b1, "bit count");
        chk(od_q.init_oe, 1'b1, "init pin");
        chk(io_pullup_q, 1'b1, "pullup");
        chk(user_mode_q, 1'b0, "user early");
    endtask
    task automatic init_internal();
        wait_obs(5, 1'b1, 4000);
        chk(io_pullup_q, 1'b0, "pullup kept");
        chk(od_q.init_oe, 1'b0, "init held");
        chk(io_hiz_q, 1'b0, "io hiz");
    endtask
    task automatic reconfig_usr();
        cfg_req_n = 1'b0;
        wait_obs(2, 1'b1, 80);
        wait_obs(1, 1'b1, 80);
        chk(io_hiz_q, 1'b1, "io not hiz");
        tick(200);
        chk(od_q.status_oe, 1'b1, "status freed");
        cfg_req_n = 1'b1;
        usr_clk_en = 1'b1;
        wait_obs(2, 1'b0, 4100);
        configure();
        tick(5000);
        chk(user_mode_q, 1'b0, "user no clk");
        usr_pulses(298);
        tick(20);
        chk(user_mode_q, 1'b0, "user at 298");
        usr_pulses(1);
        wait_obs(5, 1'b1, 50);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        cfg_req_n = 1'b1;
        usr_clk = 1'b0;
        usr_clk_en = 1'b0;
        crc_err = 1'b0;
        auto_restart = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        nbits = 0;
        tick(3);
        chk(od_q.status_oe, 1'b1, "status free");
        chk(od_q.done_oe, 1'b1, "done free");
        tick(1);
        sys_rst = 1'b0;
        power_on();
        configure();
        init_internal();
        reconfig_usr();
        err_restart();
        wrap_up();
    end
endmodule
